// *** src/accstk_unit.sv ***
// Purpose: Accumulator with push-down stack and word-memory sequencing.
// Assumes: Memory returns read data in the cycle after a read request.
// Notes: Commands are taken only while idle and never during scan_end.
`include "accstk_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module accstk_unit (
   input wire logic mclk, // Unit clock, 100 MHz.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic scan_end, // End of program scan, one-cycle pulse.
   input wire logic cmd_valid, // Command offered by the sequencer.
   input wire accstk_pkg::accstk_cmd_s cmd, // Command fields.
   input wire logic [`ACCSTK_ACC_W-1:0] result_data, // Manipulation result.
   input wire logic [`ACCSTK_WORD_W-1:0] mem_rdata, // Word read data.
   output logic cmd_ready, // Unit can take a command.
   output logic done, // Command finished, one-cycle pulse.
   output logic [`ACCSTK_ACC_W-1:0] acc_out, // Accumulator value.
   output logic [`ACCSTK_ACC_W-1:0] stack_top, // Top stack entry.
   output logic stack_lost, // Bottom entry discarded, pulse.
   output accstk_pkg::accstk_mem_s mem_req, // Word memory request.
   output accstk_pkg::accstk_flags_s flags // Status flags.
);
   logic [1:0] rst_sync_ff;
   logic rst_n;
   accstk_pkg::accstk_state_e state_ff;
   accstk_pkg::accstk_state_e nxt_state;
   accstk_pkg::accstk_cmd_s cur_ff;
   accstk_pkg::accstk_mem_s mem_ff;
   accstk_pkg::accstk_mem_s nxt_mem;
   accstk_pkg::accstk_flags_s flags_ff;
   logic [`ACCSTK_ACC_W-1:0] acc_ff;
   logic [`ACCSTK_ACC_W-1:0] nxt_acc;
   logic [`ACCSTK_WORD_W-1:0] base_ff;
   logic [`ACCSTK_WORD_W-1:0] nxt_base;
   logic [`ACCSTK_WORD_W-1:0] lo_ff;
   logic beat_ff;
   logic nxt_beat;
   logic push_pending_ff;
   logic nxt_pending;
   logic cmd_ready_ff;
   logic done_ff;
   ////////////////////////////////////////////////////////////////////////////
   // Reset release through two flops; assertion stays asynchronous.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];
   ////////////////////////////////////////////////////////////////////////////
   // Command decode. While busy the latched command steers the datapath.
   wire accept = cmd_valid && cmd_ready_ff && !scan_end && (state_ff == accstk_pkg::S_IDLE);
   wire accstk_pkg::accstk_op_e op_sel = accept ? cmd.op : cur_ff.op;
   wire op_double = (op_sel == accstk_pkg::load_double_op) || (op_sel == accstk_pkg::store_double_op);
   wire op_store = (op_sel == accstk_pkg::store_word_op) || (op_sel == accstk_pkg::store_double_op);
   wire op_mem_load = (op_sel == accstk_pkg::load_word_op) || (op_sel == accstk_pkg::load_double_op);
   wire op_indirect = accept ? cmd.indirect : cur_ff.indirect;
   wire cmd_needs_mem = op_store || (op_mem_load && cmd.use_mem);
   wire cmd_const_load = op_mem_load && !cmd.use_mem;
   wire cmd_lda = op_sel == accstk_pkg::load_address_op;
   wire last_beat = !op_double || beat_ff;
   // A double access through a pointer needs the following word too.
   wire ptr_bad = (mem_rdata >= `ACCSTK_PTR_LIMIT) || (op_double && (mem_rdata == `ACCSTK_PTR_LAST)); // RULE18
   wire ptr_check = state_ff == accstk_pkg::S_PTRW;
   wire data_done = (state_ff == accstk_pkg::S_RDW) && last_beat;
   wire store_done = (state_ff == accstk_pkg::S_WR) && last_beat;
   ////////////////////////////////////////////////////////////////////////////
   // Actions that write the accumulator.
   wire exec_load = (accept && (cmd_const_load || cmd_lda)) || data_done;
   wire exec_pop = accept && (cmd.op == accstk_pkg::pop_op);
   wire exec_result = accept && (cmd.op == accstk_pkg::result_op);
   wire acc_write = !scan_end && (exec_load || exec_pop || exec_result);
   wire stk_push = !scan_end && exec_load && push_pending_ff; // RULE5 RULE6
   wire stk_pop = exec_pop;
   wire [`ACCSTK_WORD_W-1:0] lda_value;
   wire [`ACCSTK_ACC_W-1:0] stk_top;
   wire stk_lost;
   accstk_octal_conv u_conv (
      .octal_in(cmd.data[`ACCSTK_OCT_W-1:0]),
      .bin_out(lda_value)
   );
   accstk_stack_mem u_stack (
      .clk(mclk),
      .rst_n(rst_n),
      .push(stk_push),
      .pop(stk_pop),
      .push_data(acc_ff),
      .top_data(stk_top),
      .discard(stk_lost)
   );
   ////////////////////////////////////////////////////////////////////////////
   // Load value: memory words pair low address to low half.
   wire [`ACCSTK_ACC_W-1:0] mem_value = (op_sel == accstk_pkg::load_double_op) ?
      {mem_rdata, lo_ff} : {`ACCSTK_HALF_ZERO, mem_rdata}; // RULE3 RULE14 RULE15
   wire [`ACCSTK_ACC_W-1:0] const_value = (cmd.op == accstk_pkg::load_double_op) ?
      cmd.data : {`ACCSTK_HALF_ZERO, cmd.data[`ACCSTK_WORD_W-1:0]}; // RULE3 RULE15
   wire [`ACCSTK_ACC_W-1:0] load_value = data_done ? mem_value :
      (cmd_lda ? {`ACCSTK_HALF_ZERO, lda_value} : const_value); // RULE13
   // Scan end wins over any write; the sequencer is expected to space them.
   assign nxt_acc = scan_end ? `ACCSTK_ACC_ZERO : // RULE2
                    exec_pop ? stk_top : // RULE11
                    exec_result ? result_data : // RULE4
                    exec_load ? load_value : acc_ff; // RULE1
   assign nxt_pending = scan_end ? 1'b0 :
                        exec_load ? 1'b1 :
                        store_done ? 1'b0 : push_pending_ff; // RULE7
   ////////////////////////////////////////////////////////////////////////////
   // Sequencer for pointer fetch, data reads and data writes.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         accstk_pkg::S_IDLE: begin
            if (accept && cmd_needs_mem && cmd.indirect) begin
               nxt_state = accstk_pkg::S_PTR;
            end else if (accept && cmd_needs_mem) begin
               nxt_state = op_store ? accstk_pkg::S_WR : accstk_pkg::S_RD;
            end else if (accept) begin
               nxt_state = accstk_pkg::S_FIN;
            end
         end
         accstk_pkg::S_PTR: begin
            nxt_state = accstk_pkg::S_PTRW;
         end
         accstk_pkg::S_PTRW: begin
            if (ptr_bad) begin
               nxt_state = accstk_pkg::S_FIN;
            end else begin
               nxt_state = op_store ? accstk_pkg::S_WR : accstk_pkg::S_RD;
            end
         end
         accstk_pkg::S_RD: begin
            nxt_state = accstk_pkg::S_RDW;
         end
         accstk_pkg::S_RDW: begin
            nxt_state = last_beat ? accstk_pkg::S_FIN : accstk_pkg::S_RD;
         end
         accstk_pkg::S_WR: begin
            nxt_state = last_beat ? accstk_pkg::S_FIN : accstk_pkg::S_WR;
         end
         accstk_pkg::S_FIN: begin
            nxt_state = accstk_pkg::S_IDLE;
         end
         default: begin
            nxt_state = accstk_pkg::S_IDLE;
         end
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////
   // Address base and word beat; the pointer word replaces the base.
   assign nxt_base = accept ? cmd.addr : (ptr_check ? mem_rdata : base_ff); // RULE12 RULE14
   assign nxt_beat = (accept || ptr_check) ? `ACCSTK_LO_BEAT :
                     (((state_ff == accstk_pkg::S_RDW) || (state_ff == accstk_pkg::S_WR)) && !beat_ff) ?
                     `ACCSTK_HI_BEAT : beat_ff;
   // Requests are registered, so the memory sees them one cycle after decode.
   assign nxt_mem.rd = (nxt_state == accstk_pkg::S_PTR) || (nxt_state == accstk_pkg::S_RD);
   assign nxt_mem.wr = nxt_state == accstk_pkg::S_WR;
   assign nxt_mem.addr = nxt_base + {{(`ACCSTK_WORD_W-1){1'b0}}, nxt_beat}; // RULE3
   assign nxt_mem.wdata = nxt_beat ? acc_ff[`ACCSTK_ACC_W-1:`ACCSTK_WORD_W] :
                          acc_ff[`ACCSTK_WORD_W-1:0]; // RULE16
   ////////////////////////////////////////////////////////////////////////////
   // Sequencer and request registers.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= accstk_pkg::S_IDLE;
         mem_ff <= '0;
         base_ff <= `ACCSTK_HALF_ZERO;
         beat_ff <= `ACCSTK_LO_BEAT;
         cmd_ready_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         mem_ff <= nxt_mem;
         base_ff <= nxt_base;
         beat_ff <= nxt_beat;
         cmd_ready_ff <= nxt_state == accstk_pkg::S_IDLE;
         done_ff <= nxt_state == accstk_pkg::S_FIN;
      end
   end
   // Latched command and the low word of a double read.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cur_ff <= '0;
         lo_ff <= `ACCSTK_HALF_ZERO;
      end else begin
         if (accept) begin
            cur_ff <= cmd;
         end
         if ((state_ff == accstk_pkg::S_RDW) && !beat_ff) begin
            lo_ff <= mem_rdata; // RULE3
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Accumulator, push state and flags.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         acc_ff <= `ACCSTK_ACC_ZERO;
         push_pending_ff <= 1'b0;
         flags_ff <= '0;
      end else begin
         acc_ff <= nxt_acc;
         push_pending_ff <= nxt_pending;
         flags_ff.negative <= nxt_acc[`ACCSTK_SIGN_BIT]; // RULE17
         if (acc_write) begin
            flags_ff.zero <= nxt_acc == `ACCSTK_ACC_ZERO; // RULE17
         end
         if (ptr_check) begin
            flags_ff.ptr_range <= ptr_bad; // RULE18
         end
      end
   end
   // Outputs.
   assign cmd_ready = cmd_ready_ff;
   assign done = done_ff;
   assign acc_out = acc_ff;
   assign stack_top = stk_top;
   assign stack_lost = stk_lost;
   assign mem_req = mem_ff;
   assign flags = flags_ff;
   ////////////////////////////////////////////////////////////////////////////
   // Checks on the accumulator and its sequencing.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   scan_clear_a: assert property (scan_end |=> acc_ff == `ACCSTK_ACC_ZERO) // RULE2
      else $error("accumulator not cleared at scan end");
   first_load_a: assert property (exec_load && !push_pending_ff && !scan_end
      |=> $stable(stk_top) && push_pending_ff) // RULE5
      else $error("first load disturbed the stack");
   load_push_a: assert property (exec_load && push_pending_ff && !scan_end
      |=> stk_top == $past(acc_ff)) // RULE6
      else $error("second load did not push the accumulator");
   store_cancel_a: assert property (store_done && !scan_end && !exec_load |=> !push_pending_ff) // RULE7
      else $error("store left a push pending");
   word_upper_a: assert property (data_done && (cur_ff.op == accstk_pkg::load_word_op) && !scan_end
      |=> acc_ff == {`ACCSTK_HALF_ZERO, $past(mem_rdata)}) // RULE14
      else $error("word load wrong or upper half not cleared");
   pop_move_a: assert property (exec_pop |=> acc_ff == $past(stk_top)) // RULE11
      else $error("pop did not take the top entry");
   result_take_a: assert property (exec_result |=> acc_ff == $past(result_data)) // RULE4
      else $error("result not placed in the accumulator");
   store_data_a: assert property (mem_ff.wr && !beat_ff |-> mem_ff.wdata == acc_ff[`ACCSTK_WORD_W-1:0]) // RULE16
      else $error("word store data is not the accumulator low half");
   neg_flag_a: assert property (flags_ff.negative == acc_ff[`ACCSTK_SIGN_BIT]) // RULE17
      else $error("negative flag does not follow the sign bit");
   ptr_range_a: assert property (ptr_check && ptr_bad |=> flags_ff.ptr_range && !mem_ff.rd && !mem_ff.wr) // RULE18
      else $error("bad pointer not flagged or access not stopped");
   // A direct word store finishes after two cycles; an indirect double load needs seven.
   double_done_a: assert property (accept && cmd_needs_mem |-> ##[2:7] done_ff) // RULE3
      else $error("memory command did not finish in time");
   lda_conv_a: assert property (accept && cmd_lda |=> acc_ff[`ACCSTK_ACC_W-1:`ACCSTK_WORD_W] == `ACCSTK_HALF_ZERO) // RULE13
      else $error("address load left upper half set");
   double_load_c: cover property (data_done && (cur_ff.op == accstk_pkg::load_double_op));
   indirect_c: cover property (ptr_check && !ptr_bad);
   ptr_err_c: cover property (ptr_check && ptr_bad);
   push_pop_c: cover property (stk_push ##[1:20] stk_pop);
endmodule : accstk_unit
`default_nettype wire

// *** src/accstk_defines.svh ***
// Purpose: Named constants for the accumulator and stack unit.
// Assumes: Included by its bare name from every design file.
// Notes: Types live in accstk_pkg; only numbers live here.
//
// Overview of operation
// RULE1 - Accumulator is 32 bits, eight BCD digits.
// RULE2 - Scan end clears accumulator to zero.
// RULE3 - Double load/store moves two words or constant.
// RULE4 - Manipulation result replaces the accumulator value.
// RULE5 - First load in scan pushes nothing.
// RULE6 - Later loads push old accumulator first.
// RULE7 - Store cancels the pending push.
// RULE8 - Push moves every entry down one.
// RULE9 - Stack holds eight 32-bit entries.
// RULE10 - Push with full stack loses bottom entry.
// RULE11 - Pop moves top into accumulator, shifts up.
// RULE12 - Pointer value is binary form of octal.
// RULE13 - Address load converts octal, loads accumulator.
// RULE14 - Pointer load reads designated word into low half.
// RULE15 - Word load clears accumulator upper half.
// RULE16 - Word store writes accumulator low half.
// RULE17 - Flags for negative value and zero load.
// RULE18 - Flag pointer outside the memory range.
`ifndef ACCSTK_DEFINES_SVH
`define ACCSTK_DEFINES_SVH
`define ACCSTK_ACC_W 32
`define ACCSTK_WORD_W 16
`define ACCSTK_DEPTH 8
`define ACCSTK_OCT_DIGITS 6
`define ACCSTK_OCT_W 24
`define ACCSTK_ACC_ZERO 32'h00000000
`define ACCSTK_HALF_ZERO 16'h0000
`define ACCSTK_SIGN_BIT 31
`define ACCSTK_PTR_LIMIT 16'h1000
`define ACCSTK_PTR_LAST 16'h0FFF
`define ACCSTK_LO_BEAT 1'b0
`define ACCSTK_HI_BEAT 1'b1
`endif

// *** src/accstk_pkg.sv ***
// Purpose: Types shared by the accumulator and stack unit.
// Assumes: accstk_defines.svh gives the widths.
// Notes: Nothing here is imported; users write accstk_pkg::name.
`include "accstk_defines.svh"
package accstk_pkg;
   // Operations that the sequencer can issue.
   typedef enum logic [2:0] {
      nop_op = 3'h0,
      load_word_op = 3'h1,
      load_double_op = 3'h2,
      load_address_op = 3'h3,
      store_word_op = 3'h4,
      store_double_op = 3'h5,
      pop_op = 3'h6,
      result_op = 3'h7
   } accstk_op_e;
   // Sequencing states, one-hot.
   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_PTR = 7'h02,
      S_PTRW = 7'h04,
      S_RD = 7'h08,
      S_RDW = 7'h10,
      S_WR = 7'h20,
      S_FIN = 7'h40
   } accstk_state_e;
   // One command from the sequencer.
   typedef struct packed {
      accstk_op_e op;
      logic use_mem;
      logic indirect;
      logic [`ACCSTK_WORD_W-1:0] addr;
      logic [`ACCSTK_ACC_W-1:0] data;
   } accstk_cmd_s;
   // Word memory request.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [`ACCSTK_WORD_W-1:0] addr;
      logic [`ACCSTK_WORD_W-1:0] wdata;
   } accstk_mem_s;
   // Status flags.
   typedef struct packed {
      logic negative;
      logic zero;
      logic ptr_range;
   } accstk_flags_s;
endpackage : accstk_pkg

// *** src/accstk_octal_conv.sv ***
// Purpose: Turn an octal address, one digit per nibble, into binary.
// Assumes: Each nibble holds a digit 0 to 7; bit 3 of a nibble is ignored.
// Notes: Purely combinational; the caller registers the result.
`include "accstk_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module accstk_octal_conv (
   input wire logic [`ACCSTK_OCT_W-1:0] octal_in, // Octal digits, one per nibble.
   output logic [`ACCSTK_WORD_W-1:0] bin_out // Binary equivalent, low 16 bits.
);
   logic [3*`ACCSTK_OCT_DIGITS-1:0] packed_bits;
   ////////////////////////////////////////////////////////////////////////////
   // Each octal digit is exactly three binary bits, so conversion is a repack.
   genvar g;
   generate
      for (g = 0; g < `ACCSTK_OCT_DIGITS; g = g + 1) begin : g_digit
         assign packed_bits[3*g +: 3] = octal_in[4*g +: 3]; // RULE12
      end
   endgenerate
   // Digits above 177777 octal do not fit a word and are dropped.
   assign bin_out = packed_bits[`ACCSTK_WORD_W-1:0]; // RULE13
endmodule : accstk_octal_conv
`default_nettype wire

// *** src/accstk_stack_mem.sv ***
// Purpose: Eight-level push-down stack of 32-bit words.
// Assumes: Push and pop never arrive in the same cycle.
// Notes: Entry 0 is the top; all data leave from registers.
`include "accstk_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module accstk_stack_mem (
   input wire logic clk, // Unit clock.
   input wire logic rst_n, // Synchronised reset, active low.
   input wire logic push, // Push request, one-cycle pulse.
   input wire logic pop, // Pop request, one-cycle pulse.
   input wire logic [`ACCSTK_ACC_W-1:0] push_data, // Value pushed on top.
   output logic [`ACCSTK_ACC_W-1:0] top_data, // Current top entry.
   output logic discard // Bottom entry lost, one-cycle pulse.
);
   logic [`ACCSTK_ACC_W-1:0] ent_ff [`ACCSTK_DEPTH];
   // Unpacked so that each generated cell owns its own valid bit.
   logic vld_ff [`ACCSTK_DEPTH];
   logic discard_ff;
   ////////////////////////////////////////////////////////////////////////////
   // One shifting cell per level; the bottom refills with zero on pop.
   genvar i;
   generate
      for (i = 0; i < `ACCSTK_DEPTH; i = i + 1) begin : g_ent
         wire [`ACCSTK_ACC_W-1:0] from_up;
         wire [`ACCSTK_ACC_W-1:0] from_dn;
         wire up_vld;
         wire dn_vld;
         if (i == 0) begin : g_top
            assign from_up = push_data;
            assign up_vld = 1'b1;
         end else begin : g_mid
            assign from_up = ent_ff[i-1];
            assign up_vld = vld_ff[i-1];
         end
         if (i == `ACCSTK_DEPTH-1) begin : g_bot
            assign from_dn = `ACCSTK_ACC_ZERO;
            assign dn_vld = 1'b0;
         end else begin : g_nbot
            assign from_dn = ent_ff[i+1];
            assign dn_vld = vld_ff[i+1];
         end
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               ent_ff[i] <= `ACCSTK_ACC_ZERO;
               vld_ff[i] <= 1'b0;
            end else if (push) begin
               ent_ff[i] <= from_up; // RULE8 RULE9
               vld_ff[i] <= up_vld;
            end else if (pop) begin
               ent_ff[i] <= from_dn; // RULE11
               vld_ff[i] <= dn_vld;
            end
         end
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////////////
   // The old bottom simply falls off; nothing can bring it back.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         discard_ff <= 1'b0;
      end else begin
         discard_ff <= push && vld_ff[`ACCSTK_DEPTH-1]; // RULE10
      end
   end
   assign top_data = ent_ff[0];
   assign discard = discard_ff;
   ////////////////////////////////////////////////////////////////////////////
   // Checks on the stack cells.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   bottom_discard_a: assert property (push && vld_ff[`ACCSTK_DEPTH-1] |=> discard_ff) // RULE10
      else $error("full-stack push did not report a discard");
   push_shift_a: assert property (push |=> ent_ff[1] == $past(ent_ff[0])) // RULE8
      else $error("push did not move the top entry down");
   overflow_c: cover property (push && vld_ff[`ACCSTK_DEPTH-1]);
endmodule : accstk_stack_mem
`default_nettype wire

// *** verif/accstk_mem_model.sv ***
// Purpose: Word data memory that faces the unit, one cycle read latency.
// Assumes: Only the low 12 address bits are decoded.
// Notes: The bench fills and mirrors the array before reset ends.
`timescale 1ns/1ps
`default_nettype none
module accstk_mem_model (
   input wire logic mclk, // Unit clock.
   input wire accstk_pkg::accstk_mem_s mem_req, // Request from the unit.
   output logic [15:0] mem_rdata // Read data, valid the cycle after rd.
);
   logic [15:0] mem [0:4095];
   initial mem_rdata = 16'h5A5A;
   // Outside a read the lines flip every cycle, so stale data never looks valid.
   always @(posedge mclk) begin
      if (mem_req.wr) mem[mem_req.addr[11:0]] <= mem_req.wdata;
      if (mem_req.rd) mem_rdata <= mem[mem_req.addr[11:0]];
      else mem_rdata <= ~mem_rdata;
   end
endmodule : accstk_mem_model
`default_nettype wire

// *** verif/accstk_unit_tb.sv ***
// Purpose: Self-checking bench for accstk_unit against a queue model.
// Assumes: Op codes are given as the package's 3-bit values.
// Notes: Bad-pointer cases run last, since their stack effect is unmodelled.
`timescale 1ns/1ps
`default_nettype none
module accstk_unit_tb;
   logic mclk, reset_n = 1'b0, scan_end = 1'b0, cmd_valid = 1'b0, cmd_ready, done, stack_lost;
   accstk_pkg::accstk_cmd_s cmd = '0;
   accstk_pkg::accstk_mem_s mem_req;
   accstk_pkg::accstk_flags_s flags;
   logic [31:0] result_data = 32'h0, acc_out, stack_top, acc = 32'h0, val;
   logic [15:0] mem_rdata, eff;
   logic [15:0] mir [0:4095];
   logic [31:0] stk [$];
   logic pend = 1'b0, zf = 1'b0;
   int failures = 0, n_compared = 0, lost = 0, nlost = 0, cyc = 0;
   accstk_unit u_accstk_unit (.mclk(mclk), .reset_n(reset_n), .scan_end(scan_end), .cmd_valid(cmd_valid),
      .cmd(cmd), .result_data(result_data), .mem_rdata(mem_rdata), .cmd_ready(cmd_ready), .done(done),
      .acc_out(acc_out), .stack_top(stack_top), .stack_lost(stack_lost), .mem_req(mem_req), .flags(flags));
   accstk_mem_model u_accstk_mem_model (.mclk(mclk), .mem_req(mem_req), .mem_rdata(mem_rdata));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Count discard pulses, and stop a hang long after the sequence should end.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (stack_lost === 1'b1) lost <= lost + 1;
      if (cyc == 5000) begin
         failures++;
         close_out();
      end
   end
   task automatic close_out();
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   // Octal digits one per nibble, weighted by eight.
   function automatic logic [31:0] oct(input logic [31:0] d);
      oct = 32'h0;
      for (int i = 5; i >= 0; i--) oct = oct * 8 + d[4*i +: 3];
   endfunction : oct
   ////////////////////////////////////////////////////////////////////////////////
   // Mode bit 0 selects memory as source, bit 1 adds the pointer fetch.
   task automatic run(input logic [2:0] op, input logic [1:0] m, input logic [15:0] a, input logic [31:0] d);
      int k;
      cmd <= '{accstk_pkg::accstk_op_e'(op), m[0], m[1], a, d};
      result_data <= d;
      cmd_valid <= 1'b1;
      do @(posedge mclk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (done !== 1'b1 && k < 20);
      if (k == 20) failures++;
      eff = m[1] ? mir[a] : a;
      if (m[1] && (eff >= 16'h1000 || (op == 3'h2 && eff == 16'h0FFF))) begin
         chk(flags.ptr_range, 32'h1, "range");
         return;
      end
      case (op)
         3'h1: val = {16'h0, m[0] ? mir[eff] : d[15:0]};
         3'h2: val = m[0] ? {mir[eff + 16'h1], mir[eff]} : d;
         3'h3: val = oct(d);
         3'h4: mir[a] = acc[15:0];
         3'h5: {mir[a + 16'h1], mir[a]} = acc;
         3'h6: acc = stk.size() > 0 ? stk.pop_front() : 32'h0;
         3'h7: acc = d;
         default: ;
      endcase
      if (op == 3'h4 || op == 3'h5) pend = 1'b0;
      if (op <= 3'h3) begin
         if (pend) stk.push_front(acc);
         if (stk.size() > 8) begin
            void'(stk.pop_back());
            nlost++;
         end
         acc = val;
         pend = 1'b1;
      end
      if (op <= 3'h3 || op >= 3'h6) zf = acc == 32'h0;
      chk(acc_out, acc, "acc");
      chk(stack_top, stk.size() > 0 ? stk[0] : 32'h0, "top");
      chk({flags.negative, flags.zero}, {acc[31], zf}, "flags");
      if (m[1]) chk(flags.ptr_range, 32'h0, "range");
   endtask : run
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hFE95));
      for (int i = 0; i < 4096; i++) begin
         mir[i] = 16'($urandom);
         u_accstk_mem_model.mem[i] = mir[i];
      end
      repeat (5) @(posedge mclk);
      reset_n <= 1'b1;
      // Ten constant loads overrun the eight entries.
      repeat (10) run(3'h1, 2'h0, 16'h0, $urandom);
      @(posedge mclk);
      chk(lost, nlost, "lost");
      repeat (3) run(3'h6, 2'h0, 16'h0, 32'h0);
      run(3'h2, 2'h0, 16'h0, $urandom | 32'h80000000);
      run(3'h5, 2'h0, 16'h0100, 32'h0);
      run(3'h2, 2'h1, 16'h0100, 32'h0);
      run(3'h4, 2'h0, 16'h0200, 32'h0);
      run(3'h1, 2'h1, 16'h0200, 32'h0);
      run(3'h7, 2'h0, 16'h0, 32'h0);
      run(3'h7, 2'h0, 16'h0, $urandom);
      run(3'h3, 2'h0, 16'h0, 32'h00002100);
      run(3'h3, 2'h0, 16'h0, $urandom & 32'h00177777);
      // Pointer at 0x300 names word 0x440; 0x310 and 0x311 hold out-of-range pointers.
      run(3'h1, 2'h0, 16'h0, 32'h0440);
      run(3'h4, 2'h0, 16'h0300, 32'h0);
      run(3'h1, 2'h0, 16'h0, 32'h2635);
      run(3'h4, 2'h0, 16'h0440, 32'h0);
      run(3'h1, 2'h3, 16'h0300, 32'h0);
      run(3'h2, 2'h3, 16'h0300, 32'h0);
      scan_end <= 1'b1;
      @(posedge mclk);
      scan_end <= 1'b0;
      @(posedge mclk);
      acc = 32'h0;
      pend = 1'b0;
      chk(acc_out, acc, "scan");
      run(3'h1, 2'h0, 16'h0, 32'h1000);
      run(3'h4, 2'h0, 16'h0310, 32'h0);
      run(3'h1, 2'h0, 16'h0, 32'h0FFF);
      run(3'h4, 2'h0, 16'h0311, 32'h0);
      run(3'h1, 2'h3, 16'h0310, 32'h0);
      run(3'h2, 2'h3, 16'h0311, 32'h0);
      close_out();
   end
endmodule : accstk_unit_tb
`default_nettype wire
